// ===== rtl/nistt_pkg.sv
package nistt_pkg;
    localparam int NUM_IRQ = 27;
    localparam int PRIO_W = 3;
    localparam int TICK_W = 24;
    localparam int ID_W = 5;
    localparam int ADDR_W = 12;
    // Register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_RELOAD = 12'h004;
    localparam logic [11:0] OFF_CURRENT = 12'h008;
    localparam logic [11:0] OFF_SETPEND = 12'h010;
    localparam logic [11:0] OFF_CLRPEND = 12'h014;
    localparam logic [11:0] OFF_ACTIVE = 12'h018;
    localparam logic [11:0] OFF_LEVEL = 12'h01c;
    localparam logic [11:0] OFF_SOFTWARE_TRIGGER_REGISTER = 12'h020;
    localparam logic [11:0] OFF_PRIO = 12'h040;
    // Control/status field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_INTEN_BIT = 1;
    localparam int CTRL_CLKSRC_BIT = 2;
    localparam int CTRL_COUNT_BIT = 16;
    // Priority fields: eight 4-bit slots per word
    localparam int PRIO_SLOT_W = 4;
    localparam int PRIO_PER_WORD = 8;
    // Reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [23:0] RELOAD_RST = 24'h000000;
    localparam logic [2:0] PRIO_RST = 3'h0;
    localparam logic [26:0] LEVEL_RST = 27'h0000000;

    typedef struct packed {
        logic valid;
        logic [ID_W-1:0] id;
        logic [PRIO_W-1:0] prio;
    } nistt_req_s;
endpackage

// ===== rtl/nistt_top.sv
module nistt_top #(
    parameter int NUM_IRQ = nistt_pkg::NUM_IRQ
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_IRQ-1:0] irq_lines,
    input wire logic core_enter,
    input wire logic [4:0] core_enter_id,
    input wire logic core_exit,
    input wire logic [4:0] core_exit_id,
    input wire logic tick_enter,
    input wire logic halt_debug,
    input wire logic sleep_stop,
    output nistt_pkg::nistt_req_s irq_out,
    output logic tick_pend,
    output logic stack_save,
    output logic stack_restore
);
    logic [NUM_IRQ-1:0] line_s_reg, line_q_reg;
    logic [NUM_IRQ-1:0] pend_reg, act_reg, level_reg;
    logic [NUM_IRQ-1:0] pend_next, act_next;
    logic [NUM_IRQ-1:0] rise_w, held_w, pset_w, clr_w, enter_w, exit_w;
    logic [2:0] prio_reg [NUM_IRQ];
    logic [127:0] prio_flat;
    logic [2:0] ctrl_reg;
    logic count_reg, count_next;
    logic [23:0] reload_reg, cur_reg, cur_next;
    logic tick_pend_reg, tick_pend_next;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    nistt_pkg::nistt_req_s irq_out_reg, arb_next;
    logic stack_save_reg, stack_restore_reg;

    // APB phase decode
    wire setup = psel & ~penable & ~pready_reg;
    wire done = psel & penable & pready_reg;
    wire wr = done & pwrite;
    wire rd = done & ~pwrite;
    wire hit_ctrl = paddr == nistt_pkg::OFF_CTRL;
    wire hit_reload = paddr == nistt_pkg::OFF_RELOAD;
    wire hit_cur = paddr == nistt_pkg::OFF_CURRENT;
    wire hit_setp = paddr == nistt_pkg::OFF_SETPEND;
    wire hit_clrp = paddr == nistt_pkg::OFF_CLRPEND;
    wire hit_act = paddr == nistt_pkg::OFF_ACTIVE;
    wire hit_level = paddr == nistt_pkg::OFF_LEVEL;
    wire hit_trig = paddr == nistt_pkg::OFF_SOFTWARE_TRIGGER_REGISTER;
    wire hit_prio = (paddr[11:4] == nistt_pkg::OFF_PRIO[11:4])
        & (paddr[1:0] == 2'h0);
    wire hit_any = hit_ctrl | hit_reload | hit_cur | hit_setp | hit_clrp
        | hit_act | hit_level | hit_trig | hit_prio;
    // Writes act only on full aligned words
    wire wr_ctrl = wr & hit_ctrl;
    wire wr_reload = wr & hit_reload;
    wire wr_cur = wr & hit_cur;
    wire wr_setp = wr & hit_setp;
    wire wr_clrp = wr & hit_clrp;
    wire wr_level = wr & hit_level;
    wire wr_trig = wr & hit_trig;
    wire wr_prio = wr & hit_prio;
    wire rd_ctrl = rd & hit_ctrl;

    // Read data selection
    wire [31:0] ctrl_word = {15'h0000, count_reg, 13'h0000, ctrl_reg};
    wire [31:0] prio_word = prio_flat[paddr[3:2]*32 +: 32];
    wire [31:0] rd_mux =
        ({32{hit_ctrl}} & ctrl_word)
        | ({32{hit_reload}} & {8'h00, reload_reg})
        | ({32{hit_cur}} & {8'h00, cur_reg})
        | ({32{hit_setp}} & 32'(pend_reg))
        | ({32{hit_clrp}} & 32'(pend_reg))
        | ({32{hit_act}} & 32'(act_reg))
        | ({32{hit_level}} & 32'(level_reg))
        | ({32{hit_prio}} & prio_word);

    // APB slave: answer one cycle after setup
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~hit_any;
            if (setup) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    a_apb_one_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
        setup |=> pready_reg ##1 !pready_reg)
        else $error("APB answer not one cycle after setup");
    // Unmapped addresses answer with an error
    a_apb_slverr: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        setup & ~hit_any |=> pslverr_reg && pready_reg)
        else $error("Unmapped access without error response");
    // Read data is the register value at setup
    a_apb_rdata: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        setup |=> prdata_reg == $past(rd_mux))
        else $error("Read data not taken at setup");

    // Request line sampling for edge and level detect
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            line_s_reg <= '0;
            line_q_reg <= '0;
        end else begin
            line_s_reg <= irq_lines;
            line_q_reg <= line_s_reg;
        end
    end

    // Every edge copies the request lines
    a_line_sample: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        1'b1 |=> line_s_reg == $past(irq_lines))
        else $error("Request lines not sampled each edge");

    // Per-interrupt pending and active state
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
            wire sw_set = (wr_setp & pwdata[gi])
                | (wr_trig & (pwdata[4:0] == 5'(gi)));
            wire keep;
            wire ret;
            assign enter_w[gi] = core_enter & (core_enter_id == 5'(gi));
            assign exit_w[gi] = core_exit & (core_exit_id == 5'(gi));
            assign rise_w[gi] = line_s_reg[gi] & ~line_q_reg[gi];
            // Entry marks active, exit releases
            assign act_next[gi] = enter_w[gi]
                | (act_reg[gi] & ~exit_w[gi]);
            assign held_w[gi] = line_s_reg[gi] & ~act_next[gi];
            // Level clear blocked while line high, pulse clear always
            assign clr_w[gi] = wr_clrp & pwdata[gi]
                & ~(level_reg[gi] & line_s_reg[gi]);
            assign keep = pend_reg[gi] & ~enter_w[gi] & ~clr_w[gi]
                & ~(exit_w[gi] & level_reg[gi]);
            assign ret = exit_w[gi] & level_reg[gi]
                & line_s_reg[gi];
            assign pset_w[gi] = ret | rise_w[gi] | held_w[gi] | sw_set;
            // Set beats clear in the same cycle
            assign pend_next[gi] = keep | pset_w[gi];
            assign prio_flat[gi*4 +: 4] = {1'b0, prio_reg[gi]};

            // Priority field storage
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    prio_reg[gi] <= nistt_pkg::PRIO_RST;
                end else if (wr_prio & (paddr[3:2] == 2'(gi / 8))) begin
                    prio_reg[gi] <= pwdata[(gi % 8)*4 +: 3];
                end
            end

            a_rise_pend: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                rise_w[gi] |=> pend_reg[gi])
                else $error("Rising edge did not set pending");
            a_held_pend: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                held_w[gi] |=> pend_reg[gi])
                else $error("High inactive line did not pend");
            a_enter_act: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                enter_w[gi] & ~pset_w[gi] |=> act_reg[gi]
                    & !pend_reg[gi])
                else $error("Entry did not move pending to active");
            a_level_exit: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                exit_w[gi] & level_reg[gi] & line_s_reg[gi]
                    |=> pend_reg[gi] & !act_reg[gi])
                else $error("Level exit with line high not pending");
            a_pulse_clear: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                wr_clrp & pwdata[gi] & ~level_reg[gi] & ~pset_w[gi]
                    & ~enter_w[gi] & ~exit_w[gi]
                    |=> !pend_reg[gi]
                    && act_reg[gi] == $past(act_reg[gi]))
                else $error("Pulse clear-pending misbehaved");
            // Level clear while line high keeps pending
            a_level_clr: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                wr_clrp & pwdata[gi] & level_reg[gi] & line_s_reg[gi]
                    & pend_reg[gi] & ~enter_w[gi] |=> pend_reg[gi])
                else $error("Level clear-pending dropped a held line");
            a_pulse_active: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                act_reg[gi] & ~exit_w[gi] & rise_w[gi]
                    |=> pend_reg[gi] && act_reg[gi])
                else $error("Pulse in handler not pending and active");
            a_pulse_exit: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                exit_w[gi] & ~level_reg[gi] & ~pend_reg[gi] & ~pset_w[gi]
                    & ~enter_w[gi] |=> !pend_reg[gi] && !act_reg[gi])
                else $error("Quiet pulse exit not inactive");
            a_sw_pend: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                sw_set |=> pend_reg[gi])
                else $error("Software set did not pend");
            // Priority field takes the low three bits of its slot
            a_prio_store: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                wr_prio & (paddr[3:2] == 2'(gi / 8)) |=> prio_reg[gi]
                    == $past(pwdata[(gi % 8)*4 +: 3]))
                else $error("Priority field not stored");
        end
    endgenerate
    assign prio_flat[127:NUM_IRQ*4] = '0;

    // Pending, active and mode vectors
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pend_reg <= '0;
            act_reg <= '0;
            level_reg <= nistt_pkg::LEVEL_RST;
        end else begin
            pend_reg <= pend_next;
            act_reg <= act_next;
            if (wr_level) begin
                level_reg <= pwdata[NUM_IRQ-1:0];
            end
        end
    end

    // Arbitration: smallest level wins, then lowest index
    always_comb begin
        arb_next = '0;
        for (int i = 0; i < NUM_IRQ; i++) begin
            if (pend_reg[i] & ~act_reg[i]
                & (~arb_next.valid | (prio_reg[i] < arb_next.prio))) begin
                arb_next.valid = 1'b1;
                arb_next.id = 5'(i);
                arb_next.prio = prio_reg[i];
            end
        end
    end

    // Registered request and stacking strobes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_out_reg <= '0;
            stack_save_reg <= 1'b0;
            stack_restore_reg <= 1'b0;
        end else begin
            irq_out_reg <= arb_next;
            stack_save_reg <= core_enter | tick_enter;
            stack_restore_reg <= core_exit;
        end
    end

    a_arb_winner: assert property (@(posedge ref_clk) disable iff (!rst_n)
        arb_next.valid |=> irq_out_reg.valid
            && irq_out_reg.prio <= $past(arb_next.prio)
            && irq_out_reg.id == $past(arb_next.id))
        else $error("Request output does not follow arbiter");
    // No candidate leaves the request output idle
    a_arb_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(|(pend_reg & ~act_reg)) |=> !irq_out_reg.valid)
        else $error("Request offered with nothing pending");
    // Stack strobes follow entry and return
    a_stack_save: assert property (@(posedge ref_clk) disable iff (!rst_n)
        core_enter | tick_enter |=> stack_save_reg)
        else $error("No stack save after entry");
    a_stack_rest: assert property (@(posedge ref_clk) disable iff (!rst_n)
        core_exit |=> stack_restore_reg)
        else $error("No stack restore after return");

    // Tick timer next-state
    wire tick_run = ctrl_reg[nistt_pkg::CTRL_EN_BIT]
        & ~halt_debug & ~sleep_stop;
    wire tick_hit = tick_run & ~wr_cur & (cur_reg == 24'h000001);
    assign cur_next = wr_cur ? 24'h000000
        : ~tick_run ? cur_reg
        : (cur_reg == 24'h000000) ? reload_reg
        : cur_reg - 24'h000001;
    assign count_next = ~wr_cur
        & (tick_hit | (count_reg & ~rd_ctrl));
    assign tick_pend_next = (tick_hit
        & ctrl_reg[nistt_pkg::CTRL_INTEN_BIT])
        | (tick_pend_reg & ~tick_enter);

    // Tick timer registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_reg <= nistt_pkg::CTRL_RST;
            reload_reg <= nistt_pkg::RELOAD_RST;
            cur_reg <= 24'h000000;
            count_reg <= 1'b0;
            tick_pend_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= pwdata[2:0];
            end
            if (wr_reload) begin
                reload_reg <= pwdata[23:0];
            end
            cur_reg <= cur_next;
            count_reg <= count_next;
            tick_pend_reg <= tick_pend_next;
        end
    end

    a_tick_dec: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick_run & ~wr_cur & (cur_reg != 24'h000000)
            |=> cur_reg == $past(cur_reg) - 24'h000001)
        else $error("Tick counter did not decrement");
    a_tick_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick_run & ~wr_cur & (cur_reg == 24'h000000) & ~wr_reload
            |=> cur_reg == $past(reload_reg))
        else $error("Tick counter did not reload at zero");
    a_tick_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (halt_debug | sleep_stop) & ~wr_cur |=> $stable(cur_reg))
        else $error("Tick counter moved while halted");
    a_tick_wrclr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_cur & ~tick_pend_reg |=> cur_reg == 24'h000000
            && !count_reg && !tick_pend_reg)
        else $error("Current write did not clear cleanly");
    a_count_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick_hit |=> count_reg && cur_reg == 24'h000000)
        else $error("Count flag not set at zero");
    a_tick_exc: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick_hit & ctrl_reg[nistt_pkg::CTRL_INTEN_BIT]
            |=> tick_pend_reg)
        else $error("Tick exception not made pending");
    // Taking the tick exception drops its pending state
    a_tick_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick_enter & ~tick_hit |=> !tick_pend_reg)
        else $error("Tick pending not cleared on entry");
    // Control read clears the count flag
    a_count_rdclr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_ctrl & ~tick_hit |=> !count_reg)
        else $error("Count flag not cleared by read");
    // Zero reload parks the counter at zero
    a_tick_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick_run & ~wr_cur & ~wr_reload & (cur_reg == 24'h000000)
            & (reload_reg == 24'h000000) |=> cur_reg == 24'h000000)
        else $error("Counter ran on with zero reload");

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq_out = irq_out_reg;
    assign tick_pend = tick_pend_reg;
    assign stack_save = stack_save_reg;
    assign stack_restore = stack_restore_reg;
endmodule

// ===== testbench/nistt_periph_core_model.sv
module nistt_periph_core_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [26:0] level_hold,
    input wire logic [26:0] pulse_req,
    input wire logic cmd_enter,
    input wire logic cmd_exit,
    input wire logic [4:0] cmd_id,
    output logic [26:0] irq_lines,
    output logic core_enter,
    output logic [4:0] core_enter_id,
    output logic core_exit,
    output logic [4:0] core_exit_id
);
    timeunit 1ns;
    timeprecision 1ps;
    // Peripheral request lines and core handler strobes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_lines <= '0;
            core_enter <= 1'b0;
            core_exit <= 1'b0;
            core_enter_id <= '0;
            core_exit_id <= '0;
        end else begin
            irq_lines <= level_hold | pulse_req;
            core_enter <= cmd_enter;
            core_exit <= cmd_exit;
            // Idle ids wander so a stale id is never trusted
            core_enter_id <= cmd_enter ? cmd_id : ~core_enter_id;
            core_exit_id <= cmd_exit ? cmd_id : ~core_exit_id;
        end
    end
endmodule

// ===== testbench/nistt_top_tb.sv
module nistt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic slv_err;
    logic [26:0] irq_lines, level_hold, pulse_req;
    logic core_enter, core_exit, cmd_enter, cmd_exit, tick_enter;
    logic [4:0] core_enter_id, core_exit_id, cmd_id;
    logic halt_debug, sleep_stop, tick_pend, stack_save, stack_restore;
    nistt_pkg::nistt_req_s irq_out;
    int n_errors, samples_checked, n;
    nistt_top nistt_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_lines(irq_lines), .core_enter(core_enter),
        .core_enter_id(core_enter_id), .core_exit(core_exit),
        .core_exit_id(core_exit_id), .tick_enter(tick_enter),
        .halt_debug(halt_debug), .sleep_stop(sleep_stop), .irq_out(irq_out),
        .tick_pend(tick_pend), .stack_save(stack_save),
        .stack_restore(stack_restore));
    nistt_periph_core_model nistt_periph_core_model_i (.ref_clk(ref_clk),
        .rst_n(rst_n), .level_hold(level_hold), .pulse_req(pulse_req),
        .cmd_enter(cmd_enter), .cmd_exit(cmd_exit), .cmd_id(cmd_id),
        .irq_lines(irq_lines), .core_enter(core_enter),
        .core_enter_id(core_enter_id), .core_exit(core_exit),
        .core_exit_id(core_exit_id));
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    // One aligned full-word APB transfer; read data lands in q
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20)
            chk(32'h1, 32'h0);
        q = prdata;
        slv_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never reassigns in this step
        @(posedge ref_clk);
    endtask
    task automatic st(input logic [31:0] p, input logic [31:0] a);
        apb(1'b0, nistt_pkg::OFF_SETPEND, '0);
        chk(q, p);
        apb(1'b0, nistt_pkg::OFF_ACTIVE, '0);
        chk(q, a);
    endtask
    // Core enters or leaves a handler, stack strobe must follow
    task automatic core_op(input logic ent, input logic [4:0] id);
        int k;
        cmd_enter <= ent;
        cmd_exit <= !ent;
        cmd_id <= id;
        @(posedge ref_clk);
        cmd_enter <= 1'b0;
        cmd_exit <= 1'b0;
        k = 0;
        while ((ent ? stack_save : stack_restore) !== 1'b1 && k < 8) begin
            @(posedge ref_clk);
            k++;
        end
        chk(32'(k < 8), 32'h1);
        settle(3);
    endtask
    task automatic pulse(input int i);
        pulse_req[i] <= 1'b1;
        @(posedge ref_clk);
        pulse_req[i] <= 1'b0;
        settle(4);
    endtask
    task automatic t_reset_map;
        apb(1'b0, nistt_pkg::OFF_CTRL, '0);
        chk(q, '0);
        apb(1'b0, 12'h0fc, '0);
        chk({q[30:0], slv_err}, 32'h1);
        st('0, '0);
    endtask
    task automatic t_level;
        apb(1'b1, nistt_pkg::OFF_LEVEL, 32'h8);
        level_hold[3] <= 1'b1;
        settle(4);
        st(32'h8, '0);
        core_op(1'b1, 5'd3);
        st('0, 32'h8);
        core_op(1'b0, 5'd3);
        st(32'h8, '0);
        apb(1'b1, nistt_pkg::OFF_CLRPEND, 32'h8);
        st(32'h8, '0);
        core_op(1'b1, 5'd3);
        level_hold[3] <= 1'b0;
        settle(4);
        core_op(1'b0, 5'd3);
        st('0, '0);
    endtask
    task automatic t_pulse;
        pulse(5);
        st(32'h20, '0);
        core_op(1'b1, 5'd5);
        pulse(5);
        st(32'h20, 32'h20);
        apb(1'b1, nistt_pkg::OFF_CLRPEND, 32'h20);
        st('0, 32'h20);
        pulse(5);
        core_op(1'b0, 5'd5);
        st(32'h20, '0);
        core_op(1'b1, 5'd5);
        core_op(1'b0, 5'd5);
        st('0, '0);
    endtask
    task automatic t_prio;
        apb(1'b1, nistt_pkg::OFF_PRIO, 32'h50);
        apb(1'b1, nistt_pkg::OFF_PRIO + 12'h4, 32'h20);
        apb(1'b1, nistt_pkg::OFF_PRIO + 12'hc, 32'hf00);
        apb(1'b0, nistt_pkg::OFF_PRIO + 12'hc, '0);
        chk(q, 32'h700);
        apb(1'b1, nistt_pkg::OFF_SETPEND, 32'h0400_0202);
        settle(3);
        chk(32'(irq_out), {23'h0, 1'b1, 5'd9, 3'd2});
        apb(1'b1, nistt_pkg::OFF_CLRPEND, 32'h0400_0200);
        settle(3);
        chk(32'(irq_out), {23'h0, 1'b1, 5'd1, 3'd5});
        apb(1'b1, nistt_pkg::OFF_CLRPEND, 32'h2);
        apb(1'b1, nistt_pkg::OFF_SOFTWARE_TRIGGER_REGISTER, 32'd12);
        st(32'h1000, '0);
        apb(1'b1, nistt_pkg::OFF_CLRPEND, 32'h1000);
    endtask
    task automatic t_tick;
        logic [31:0] c0;
        apb(1'b1, nistt_pkg::OFF_RELOAD, 32'h3);
        apb(1'b1, nistt_pkg::OFF_CTRL, 32'h3);
        n = 0;
        while (tick_pend !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        chk(32'(n < 50), 32'h1);
        tick_enter <= 1'b1;
        @(posedge ref_clk);
        tick_enter <= 1'b0;
        // Look between edges; two edges since the first hit
        @(negedge ref_clk);
        n = 2;
        while (tick_pend !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n, 32'd4);
        @(posedge ref_clk);
        halt_debug <= 1'b1;
        apb(1'b0, nistt_pkg::OFF_CTRL, '0);
        chk(q, 32'h10003);
        apb(1'b0, nistt_pkg::OFF_CURRENT, '0);
        c0 = q;
        chk(c0, 32'h3);
        apb(1'b0, nistt_pkg::OFF_CTRL, '0);
        chk(q, 32'h3);
        apb(1'b0, nistt_pkg::OFF_CURRENT, '0);
        chk(q, c0);
        apb(1'b1, nistt_pkg::OFF_CURRENT, 32'h5a);
        apb(1'b0, nistt_pkg::OFF_CURRENT, '0);
        chk(q, '0);
        halt_debug <= 1'b0;
        sleep_stop <= 1'b1;
        settle(6);
        apb(1'b0, nistt_pkg::OFF_CURRENT, '0);
        chk(q, '0);
        sleep_stop <= 1'b0;
        apb(1'b1, nistt_pkg::OFF_RELOAD, '0);
        settle(10);
        apb(1'b0, nistt_pkg::OFF_CURRENT, '0);
        chk(q, '0);
    endtask
    // Watchdog
    initial begin
        settle(20000);
        n_errors++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {rst_n, psel, penable, pwrite, cmd_enter, cmd_exit} = '0;
        {tick_enter, halt_debug, sleep_stop} = '0;
        {paddr, pwdata, level_hold, pulse_req, cmd_id} = '0;
        n_errors = 0;
        samples_checked = 0;
        settle(3);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset_map();
        t_level();
        t_pulse();
        t_prio();
        t_tick();
        wrap_up();
    end
endmodule
